// *** src/whb_host_port.sv ***
// Purpose: windowed host bus port with service acknowledge and vector return
// Assumes: host pins asynchronous, posts from channel logic on ref_clk
// Notes: all host pins pass the two-stage synchroniser first
// Overview of operation
// RULE_01 - Channel access pointer forms upper internal address for channel registers.
// RULE_02 - Host port: 8-bit two-way data, 7-bit address, cycle strobes.
// RULE_03 - Internal clock is system clock divided by two.
// RULE_04 - Strobes, address and write data sampled on internal falling edges.
// RULE_05 - Started cycle runs address, data, acknowledge at fixed clock steps.
// RULE_06 - Strobes missed at a sampling edge start two system clocks later.
// RULE_07 - Read needs chip select, data strobe, read/write high; latest strobe counts.
// RULE_08 - Read drives addressed register data then asserts transfer acknowledge.
// RULE_09 - Host ends a read by removing both strobes after acknowledge.
// RULE_10 - Write with read/write low; acknowledge after data taken.
// RULE_11 - Acknowledge input replaces chip select; returns that kind's vector.
// RULE_12 - Service acknowledge cycle ends with transfer acknowledge, host removes strobes.
// RULE_13 - After end-of-service write, next access held off about one microsecond.
// RULE_14 - Pointer restore and housekeeping finish before host may modify registers.
// RULE_15 - Access started during housekeeping is stretched, acknowledge withheld.
// RULE_16 - Host ignoring acknowledge must delay itself after end-of-service write.
// RULE_17 - Most locations in register RAM; service status and modem inputs live.
// RULE_18 - Channel 0 parallel mode times printer strobe and handles printer acknowledge.
// RULE_19 - Posted vector carries base vector upper five bits, request type low three.
// RULE_20 - Service acknowledge loads requesting channel into channel access pointer.
// RULE_21 - Acknowledge and data drive released once host removes the strobes.
`timescale 1ns/1ns
module whb_host_port
  import whb_pkg::*;
#(
  parameter int EOS_HOLD_CYC = WHB_EOS_HOLD_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic [2:0] service_ack_n,
  input wire logic [WHB_ADDR_W-1:0] host_addr,
  input wire logic [WHB_DATA_W-1:0] host_data_in,
  output logic [WHB_DATA_W-1:0] host_data_out,
  output logic host_data_oe,
  output logic transfer_acknowledge_n,
  input wire whb_post_type post_req,
  output logic [2:0] service_request_n,
  input wire logic [WHB_NUM_CH*WHB_MODEM_W-1:0] modem_in,
  input wire logic printer_ack_n,
  output logic printer_strobe_n,
  output logic [WHB_DATA_W-1:0] printer_data
);
  // Hold-off counter is 16 bits wide and must count at least once
  if (EOS_HOLD_CYC < 1 || EOS_HOLD_CYC > 65535) begin : g_bad_hold
    $error("EOS_HOLD_CYC out of range");
  end

  // Pin synchronisers
  logic [WHB_SYNC_W-1:0] pins_raw;
  logic [WHB_SYNC_W-1:0] pins_s;
  whb_strb_type strb;
  logic [WHB_ADDR_W-1:0] addr_s;
  logic [WHB_DATA_W-1:0] wdata_s;
  logic printer_ack_n_n_s;
  logic [WHB_NUM_CH*WHB_MODEM_W-1:0] modem_s;
  localparam logic [WHB_SYNC_W-1:0] SYNC_RST =
    {6'b111111, {(WHB_SYNC_W-6){1'b0}}};

  assign pins_raw = {chip_select_n, data_strobe_n, read_write, service_ack_n,
    host_addr, host_data_in, printer_ack_n, modem_in};

  whb_sync #(.W(WHB_SYNC_W), .RST_VAL(SYNC_RST)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .d(pins_raw),
    .q(pins_s)
  );

  assign {strb, addr_s, wdata_s, printer_ack_n_n_s, modem_s} = pins_s;

  // Internal clock phase
  logic phase_r;
  logic sample_edge;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_r <= 1'b0;
    end else begin
      phase_r <= ~phase_r; // RULE_03
    end
  end
  // Internal clock falls on the edge where phase_r leaves 1
  assign sample_edge = phase_r; // RULE_04

  // Request decode
  logic cs_req;
  logic ack_req;
  logic any_req;
  logic all_off;
  logic [1:0] ack_kind;
  assign cs_req = !strb.cs_n && !strb.ds_n; // RULE_07
  assign ack_req = !strb.ds_n && (strb.svc_ack_n != 3'b111); // RULE_11
  assign any_req = cs_req || ack_req;
  assign all_off = strb.cs_n && strb.ds_n && (strb.svc_ack_n == 3'b111);
  assign ack_kind = !strb.svc_ack_n[0] ? WHB_KIND_RX :
    (!strb.svc_ack_n[1] ? WHB_KIND_TX : WHB_KIND_MDM);

  // State
  whb_state_type state_r, state_nxt;
  logic [15:0] hold_cnt_r;
  logic hold_busy;
  logic [WHB_ADDR_W-1:0] addr_r;
  logic [WHB_DATA_W-1:0] wdata_r;
  logic wr_r;
  logic svc_r;
  logic [1:0] kind_r;
  logic [WHB_CH_W-1:0] chan_ptr_r;
  logic [WHB_CH_W-1:0] saved_ptr_r;
  logic in_ctx_r;
  logic [7:0] cfg_r;
  logic [7:0] base_vec_r;
  logic [7:0] pwidth_r;
  logic [2:0] pend_r;
  logic [7:0] vec_r [0:2];
  logic [WHB_CH_W-1:0] req_chan_r [0:2];

  assign hold_busy = (hold_cnt_r != 16'h0000);

  logic start;
  assign start = sample_edge && any_req && !hold_busy; // RULE_06 RULE_15

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      WHB_ST_IDLE: if (start) state_nxt = WHB_ST_ADDR;
      WHB_ST_ADDR: state_nxt = WHB_ST_DATA; // RULE_05
      WHB_ST_DATA: state_nxt = WHB_ST_END;
      WHB_ST_END: if (all_off) state_nxt = WHB_ST_IDLE; // RULE_21
    endcase
  end

  // Address windowing
  logic is_chan;
  logic [WHB_RAM_AW-1:0] ram_addr;
  logic ram_we;
  logic [WHB_DATA_W-1:0] ram_rdata;
  assign is_chan = (addr_r >= WHB_CHAN_BASE);
  assign ram_addr = is_chan ? {chan_ptr_r, addr_r} : {{WHB_CH_W{1'b0}}, addr_r}; // RULE_01

  logic wr_go;
  assign wr_go = (state_r == WHB_ST_ADDR) && wr_r && !svc_r; // RULE_10
  assign ram_we = wr_go; // RULE_17

  whb_reg_ram #(.AW(WHB_RAM_AW), .DW(WHB_DATA_W)) u_ram (
    .ref_clk(ref_clk),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(wdata_r),
    .rdata(ram_rdata)
  );

  // Write decode
  logic wr_cfg, wr_base, wr_eos, wr_ptr, wr_pw, wr_pdata;
  assign wr_cfg = wr_go && (addr_r == WHB_OFS_CFG);
  assign wr_base = wr_go && (addr_r == WHB_OFS_BASE_VEC);
  assign wr_eos = wr_go && (addr_r == WHB_OFS_EOS);
  assign wr_ptr = wr_go && (addr_r == WHB_OFS_CHAN_PTR);
  assign wr_pw = wr_go && (addr_r == WHB_OFS_PWIDTH);
  assign wr_pdata = wr_go && (addr_r == WHB_OFS_PDATA) && cfg_r[WHB_CFG_PAR_BIT];

  // Service acknowledge start
  logic ack_go;
  assign ack_go = (state_r == WHB_ST_ADDR) && svc_r;

  // Printer handshake state
  whb_pstate_type pst_r, pst_nxt;
  logic [7:0] pcnt_r, pcnt_nxt;
  logic printer_ack_n_seen_r;
  logic pbusy;
  assign pbusy = (pst_r != WHB_PS_IDLE);

  // Read mux
  logic [WHB_MODEM_W-1:0] modem_ch;
  logic [7:0] live_data;
  logic live_hit;
  assign modem_ch = modem_s[chan_ptr_r*WHB_MODEM_W +: WHB_MODEM_W];
  assign live_hit = (addr_r == WHB_OFS_CFG) || (addr_r == WHB_OFS_SRS) ||
    (addr_r == WHB_OFS_BASE_VEC) || (addr_r == WHB_OFS_CHAN_PTR) ||
    (addr_r == WHB_OFS_PSTAT) || (addr_r == WHB_OFS_PWIDTH) ||
    (addr_r == WHB_OFS_MODEM);
  always_comb begin
    live_data = 8'h00;
    unique case (addr_r)
      WHB_OFS_CFG: live_data = cfg_r;
      WHB_OFS_SRS: live_data = {5'h00, pend_r}; // RULE_17
      WHB_OFS_BASE_VEC: live_data = base_vec_r;
      WHB_OFS_CHAN_PTR: live_data = {6'h00, chan_ptr_r};
      WHB_OFS_PSTAT: live_data = {6'h00, printer_ack_n_seen_r, pbusy};
      WHB_OFS_PWIDTH: live_data = pwidth_r;
      WHB_OFS_MODEM: live_data = {4'h0, modem_ch}; // RULE_17
      default: live_data = 8'h00;
    endcase
  end

  logic [7:0] rd_data;
  assign rd_data = svc_r ? vec_r[kind_r] : (live_hit ? live_data : ram_rdata);

  // Host cycle sequencer
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= WHB_ST_IDLE;
      addr_r <= '0;
      wdata_r <= '0;
      wr_r <= 1'b0;
      svc_r <= 1'b0;
      kind_r <= WHB_KIND_RX;
    end else begin
      state_r <= state_nxt;
      if (start && state_r == WHB_ST_IDLE) begin
        addr_r <= addr_s; // RULE_04
        wdata_r <= wdata_s;
        wr_r <= !ack_req && !strb.rw;
        svc_r <= ack_req;
        kind_r <= ack_kind;
      end
    end
  end

  // Data bus and acknowledge
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      host_data_out <= 8'h00;
      host_data_oe <= 1'b0;
      transfer_acknowledge_n <= 1'b1;
    end else begin
      if (state_r == WHB_ST_DATA) begin
        if (!wr_r) begin
          host_data_out <= rd_data; // RULE_08 RULE_11
          host_data_oe <= 1'b1; // RULE_02
        end
        transfer_acknowledge_n <= 1'b0; // RULE_08 RULE_10 RULE_12
      end else if (state_r == WHB_ST_END && all_off) begin
        host_data_oe <= 1'b0; // RULE_21
        transfer_acknowledge_n <= 1'b1;
      end
    end
  end

  // Pointer, context and hold-off
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      chan_ptr_r <= '0;
      saved_ptr_r <= '0;
      in_ctx_r <= 1'b0;
      hold_cnt_r <= 16'h0000;
      cfg_r <= WHB_CFG_RST;
      base_vec_r <= WHB_BASE_VEC_RST;
      pwidth_r <= WHB_PWIDTH_RST;
    end else begin
      if (ack_go) begin
        if (!in_ctx_r) begin
          saved_ptr_r <= chan_ptr_r;
        end
        chan_ptr_r <= req_chan_r[kind_r]; // RULE_20
        in_ctx_r <= 1'b1;
      end else if (wr_eos) begin
        chan_ptr_r <= saved_ptr_r; // RULE_14
        in_ctx_r <= 1'b0;
      end else if (wr_ptr) begin
        chan_ptr_r <= wdata_r[WHB_CH_W-1:0]; // RULE_01
      end
      if (wr_eos) begin
        hold_cnt_r <= 16'(EOS_HOLD_CYC); // RULE_13
      end else if (hold_busy) begin
        hold_cnt_r <= hold_cnt_r - 16'h0001;
      end
      if (wr_cfg) cfg_r <= wdata_r;
      if (wr_base) base_vec_r <= wdata_r;
      if (wr_pw) pwidth_r <= wdata_r;
    end
  end

  // Service requests and vectors
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_req
      logic post_k;
      logic clr_k;
      assign post_k = post_req.valid && (post_req.kind == 2'(k)) && !pend_r[k];
      assign clr_k = ack_go && (kind_r == 2'(k));
      always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
          pend_r[k] <= 1'b0;
          vec_r[k] <= 8'h00;
          req_chan_r[k] <= '0;
          service_request_n[k] <= 1'b1;
        end else begin
          if (post_k) begin
            pend_r[k] <= 1'b1;
            vec_r[k] <= {base_vec_r[7:WHB_VEC_HI_LSB], post_req.vtype}; // RULE_19
            req_chan_r[k] <= post_req.chan;
            service_request_n[k] <= 1'b0;
          end else if (clr_k) begin
            pend_r[k] <= 1'b0;
            service_request_n[k] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // Printer strobe timing on channel 0
  always_comb begin
    pst_nxt = pst_r;
    pcnt_nxt = pcnt_r;
    unique case (pst_r)
      WHB_PS_IDLE: begin
        if (wr_pdata) begin
          pst_nxt = WHB_PS_SETUP; // RULE_18
          pcnt_nxt = WHB_PSETUP_CYC;
        end
      end
      WHB_PS_SETUP: begin
        if (pcnt_r == 8'h00) begin
          pst_nxt = WHB_PS_STROBE;
          pcnt_nxt = pwidth_r;
        end else begin
          pcnt_nxt = pcnt_r - 8'h01;
        end
      end
      WHB_PS_STROBE: begin
        if (pcnt_r == 8'h00) begin
          pst_nxt = WHB_PS_WACK;
        end else begin
          pcnt_nxt = pcnt_r - 8'h01;
        end
      end
      WHB_PS_WACK: if (!printer_ack_n_n_s) pst_nxt = WHB_PS_IDLE; // RULE_18
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pst_r <= WHB_PS_IDLE;
      pcnt_r <= 8'h00;
      printer_ack_n_seen_r <= 1'b0;
      printer_strobe_n <= 1'b1;
      printer_data <= 8'h00;
    end else begin
      pst_r <= pst_nxt;
      pcnt_r <= pcnt_nxt;
      printer_strobe_n <= (pst_nxt != WHB_PS_STROBE); // RULE_18
      if (wr_pdata && !pbusy) begin
        printer_data <= wdata_r;
      end
      if (pst_r == WHB_PS_WACK && !printer_ack_n_n_s) begin
        printer_ack_n_seen_r <= 1'b1;
      end else if (wr_pdata) begin
        printer_ack_n_seen_r <= 1'b0;
      end
    end
  end
endmodule // whb_host_port

// *** src/whb_pkg.sv ***
// Purpose: shared constants and types of the windowed host bus interface
// Assumes: 25 MHz system clock, 8-bit data, 7-bit address, four channels
// Notes: offsets are 7-bit host addresses
package whb_pkg;
  localparam int WHB_DATA_W = 8;
  localparam int WHB_ADDR_W = 7;
  localparam int WHB_NUM_CH = 4;
  localparam int WHB_CH_W = 2;
  localparam int WHB_RAM_AW = WHB_CH_W + WHB_ADDR_W;
  localparam int WHB_MODEM_W = 4;
  // Addresses at or above this are channel-specific
  localparam logic [6:0] WHB_CHAN_BASE = 7'h10;
  localparam logic [6:0] WHB_OFS_CFG = 7'h01;
  localparam logic [6:0] WHB_OFS_SRS = 7'h02;
  localparam logic [6:0] WHB_OFS_BASE_VEC = 7'h03;
  localparam logic [6:0] WHB_OFS_EOS = 7'h04;
  localparam logic [6:0] WHB_OFS_CHAN_PTR = 7'h05;
  localparam logic [6:0] WHB_OFS_PSTAT = 7'h06;
  localparam logic [6:0] WHB_OFS_PWIDTH = 7'h07;
  localparam logic [6:0] WHB_OFS_PDATA = 7'h08;
  localparam logic [6:0] WHB_OFS_MODEM = 7'h6C;
  localparam int WHB_CFG_PAR_BIT = 0;
  localparam int WHB_VEC_HI_LSB = 3;
  localparam logic [7:0] WHB_CFG_RST = 8'h00;
  localparam logic [7:0] WHB_BASE_VEC_RST = 8'h00;
  localparam logic [7:0] WHB_PWIDTH_RST = 8'h0A;
  localparam logic [7:0] WHB_PSETUP_CYC = 8'h02;
  // Request kinds
  localparam logic [1:0] WHB_KIND_RX = 2'h0;
  localparam logic [1:0] WHB_KIND_TX = 2'h1;
  localparam logic [1:0] WHB_KIND_MDM = 2'h2;
  // Exit housekeeping hold-off after an end-of-service write
  localparam int WHB_CLK_MHZ = 25;
  localparam int WHB_EOS_HOLD_NS = 1000;
  localparam int WHB_EOS_HOLD_CYC = (WHB_EOS_HOLD_NS * WHB_CLK_MHZ) / 1000;
  localparam int WHB_SYNC_W = 1 + 1 + 1 + 3 + WHB_ADDR_W + WHB_DATA_W + 1
    + WHB_NUM_CH * WHB_MODEM_W;

  typedef struct packed {
    logic cs_n;
    logic ds_n;
    logic rw;
    logic [2:0] svc_ack_n;
  } whb_strb_type;

  typedef struct packed {
    logic valid;
    logic [1:0] kind;
    logic [1:0] chan;
    logic [2:0] vtype;
  } whb_post_type;

  typedef enum logic [1:0] {
    WHB_ST_IDLE = 2'b00,
    WHB_ST_ADDR = 2'b01,
    WHB_ST_DATA = 2'b10,
    WHB_ST_END = 2'b11
  } whb_state_type;

  typedef enum logic [1:0] {
    WHB_PS_IDLE = 2'b00,
    WHB_PS_SETUP = 2'b01,
    WHB_PS_STROBE = 2'b10,
    WHB_PS_WACK = 2'b11
  } whb_pstate_type;
endpackage

// *** src/whb_sync.sv ***
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes: first stage feeds only the second
`timescale 1ns/1ns
module whb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule // whb_sync

// *** src/whb_reg_ram.sv ***
// Purpose: register RAM bank behind the host port
// Assumes: one port, synchronous write, registered read
// Notes: contents undefined after reset
`timescale 1ns/1ns
module whb_reg_ram #(
  parameter int AW = 9,
  parameter int DW = 8
) (
  input wire logic ref_clk,
  input wire logic we,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule // whb_reg_ram

// *** verif/whb_host_port_chk.sv ***
// Purpose: port checker of the host port
// Assumes: host holds its strobes until acknowledge
// Notes: bound into every host port instance
`timescale 1ns/1ns
module whb_host_port_chk
  import whb_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic chip_select_n,
  input wire logic data_strobe_n,
  input wire logic read_write,
  input wire logic [2:0] service_ack_n,
  input wire logic host_data_oe,
  input wire logic transfer_acknowledge_n,
  input wire whb_post_type post_req,
  input wire logic [2:0] service_request_n,
  input wire logic printer_strobe_n,
  input wire logic [WHB_DATA_W-1:0] printer_data
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic sel_w = !chip_select_n || !(&service_ack_n);
  wire logic idle_w = chip_select_n && data_strobe_n && (&service_ack_n);
  property p_ack_sel;
    $fell(transfer_acknowledge_n) |-> !data_strobe_n && sel_w;
  endproperty
  a_ack_sel: assert property (p_ack_sel) else $error("acknowledge without request");
  property p_ack_late;
    $fell(transfer_acknowledge_n) |-> $past(!data_strobe_n, 4) && $past(sel_w, 4);
  endproperty
  a_ack_late: assert property (p_ack_late) else $error("acknowledge too early");
  property p_rel;
    idle_w [*4] |-> transfer_acknowledge_n && !host_data_oe;
  endproperty
  a_rel: assert property (p_rel) else $error("bus not released");
  property p_wr_oe;
    !transfer_acknowledge_n && !read_write |-> !host_data_oe;
  endproperty
  a_wr_oe: assert property (p_wr_oe) else $error("bus driven in write");
  property p_rd_oe;
    $fell(transfer_acknowledge_n) && read_write |-> host_data_oe;
  endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read data not driven");
  property p_ack_hold;
    !transfer_acknowledge_n && !data_strobe_n |=> !transfer_acknowledge_n;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("acknowledge dropped");
  property p_post;
    post_req.valid && post_req.kind != 2'h3 && service_request_n[post_req.kind]
      |=> !service_request_n[$past(post_req.kind)];
  endproperty
  a_post: assert property (p_post) else $error("request not raised");
  property p_pdata;
    !printer_strobe_n |-> $stable(printer_data);
  endproperty
  a_pdata: assert property (p_pdata) else $error("printer data moved");
endmodule // whb_host_port_chk

bind whb_host_port whb_host_port_chk u_whb_host_port_chk (
  .ref_clk(ref_clk), .rst_b(rst_b), .chip_select_n(chip_select_n),
  .data_strobe_n(data_strobe_n), .read_write(read_write), .service_ack_n(service_ack_n),
  .host_data_oe(host_data_oe), .transfer_acknowledge_n(transfer_acknowledge_n),
  .post_req(post_req), .service_request_n(service_request_n),
  .printer_strobe_n(printer_strobe_n), .printer_data(printer_data)
);

// *** verif/whb_host_model.sv ***
// Purpose: host bus master in front of the host port
// Assumes: acknowledge watched on every cycle
// Notes: data lines driven only while writing
`timescale 1ns/1ns
module whb_host_model (
  input wire logic ref_clk,
  input wire logic ack_n,
  output logic cs_n,
  output logic ds_n,
  output logic rw,
  output logic [2:0] svc_n,
  output logic [6:0] addr,
  output logic [7:0] wdata,
  output logic wdrive
);
  initial begin
    cs_n = 1'b1;
    ds_n = 1'b1;
    rw = 1'b1;
    svc_n = 3'h7;
    addr = 7'h00;
    wdata = 8'h00;
    wdrive = 1'b0;
  end
  task automatic acc(input logic svc, input logic [1:0] k, input logic rd,
    input logic [6:0] a, input logic [7:0] d, input int lag, output int lat);
    int n;
    @(posedge ref_clk);
    rw <= rd;
    addr <= a;
    wdata <= d;
    wdrive <= !rd;
    if (svc) svc_n[k] <= 1'b0;
    else cs_n <= 1'b0;
    repeat (lag) @(posedge ref_clk);
    ds_n <= 1'b0;
    lat = 0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while (ack_n !== 1'b0 && lat < 200);
    cs_n <= 1'b1;
    ds_n <= 1'b1;
    svc_n <= 3'h7;
    wdrive <= 1'b0;
    n = 0;
    while (ack_n !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
  endtask
endmodule // whb_host_model

// *** verif/tb_whb_host_port.sv ***
// Purpose: self-checking bench of the host port
// Assumes: host model holds strobes until acknowledge
// Notes: read data checked against a queue of expected bytes
`timescale 1ns/1ns
module tb_whb_host_port
  import whb_pkg::*;
;
  typedef struct packed {logic [7:0] v; logic [7:0] m;} whb_exp_type;
  localparam int SLOW = WHB_EOS_HOLD_CYC / 2;
  logic ref_clk, rst_b, cs_n, ds_n, rw, wdrive, printer_ack_n_n, oe, ack_n, pstb_n;
  logic ack_d = 1'b1;
  logic [7:0] junk_r = 8'hA5;
  logic [2:0] svc_n, srq_n, vt;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, pdata, g, b;
  logic [7:0] d [4];
  logic [1:0] ch;
  logic [15:0] modem;
  whb_post_type post;
  whb_exp_type exp_q[$];
  whb_exp_type cur;
  int n_mismatch = 0;
  int checks_done = 0;
  int seed = 32'h7713;
  int pcnt = 0;
  int pwid = 0;
  wire logic [7:0] bus_w = oe ? rdata : (wdrive ? wdata : junk_r);
  whb_host_port u_whb_host_port (.ref_clk(ref_clk), .rst_b(rst_b), .chip_select_n(cs_n),
    .data_strobe_n(ds_n), .read_write(rw), .service_ack_n(svc_n), .host_addr(addr),
    .host_data_in(bus_w), .host_data_out(rdata), .host_data_oe(oe),
    .transfer_acknowledge_n(ack_n), .post_req(post), .service_request_n(srq_n),
    .modem_in(modem), .printer_ack_n(printer_ack_n_n), .printer_strobe_n(pstb_n),
    .printer_data(pdata));
  whb_host_model u_whb_host_model (.ref_clk(ref_clk), .ack_n(ack_n), .cs_n(cs_n),
    .ds_n(ds_n), .rw(rw), .svc_n(svc_n), .addr(addr), .wdata(wdata), .wdrive(wdrive));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    if (n_mismatch == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic svc, input logic [1:0] k, input logic rd,
    input logic [6:0] a, input logic [7:0] v, input logic [7:0] m, input logic slow);
    int lat;
    if (rd) exp_q.push_back('{v, m});
    u_whb_host_model.acc(svc, k, rd, a, v, $unsigned($random(seed)) % 3, lat);
    if (slow) chk(16'(lat > SLOW && lat <= WHB_EOS_HOLD_CYC + 8), 16'h1);
    else chk(16'(lat >= 5 && lat <= 8), 16'h1);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    xfer(1'b0, 2'h0, 1'b0, a, v, 8'h00, 1'b0);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] v, input logic [7:0] m);
    xfer(1'b0, 2'h0, 1'b1, a, v, m, 1'b0);
  endtask
  // Read data taken when acknowledge falls
  always @(negedge ref_clk) begin
    ack_d <= ack_n;
    if (ack_d === 1'b1 && ack_n === 1'b0 && oe === 1'b1) begin
      if (exp_q.size() == 0) chk(16'h1, 16'h0);
      else begin
        cur = exp_q.pop_front();
        chk({8'h00, rdata & cur.m}, {8'h00, cur.v & cur.m});
      end
    end
  end
  // Printer strobe width in clocks
  always @(posedge ref_clk) begin
    junk_r <= ~junk_r;
    if (pstb_n === 1'b0) pcnt++;
    else if (pcnt != 0) begin
      pwid = pcnt;
      pcnt = 0;
    end
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    printer_ack_n_n = 1'b1;
    post = '0;
    modem = 16'h0000;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    modem <= 16'($random(seed));
    chk({13'h0, srq_n}, 16'h7);
    chk({14'h0, ack_n, oe}, 16'h2);
    for (int c = 0; c < 4; c++) begin
      d[c] = 8'($random(seed));
      wr(WHB_OFS_CHAN_PTR, 8'(c));
      wr(7'h20, d[c]);
    end
    g = 8'($random(seed));
    wr(7'h0A, g);
    for (int c = 3; c >= 0; c--) begin
      wr(WHB_OFS_CHAN_PTR, 8'(c));
      rd(7'h20, d[c], 8'hFF);
      rd(WHB_OFS_MODEM, {4'h0, modem[4*c +: 4]}, 8'hFF);
    end
    rd(7'h0A, g, 8'hFF);
    for (int k = 0; k < 3; k++) begin
      b = 8'($random(seed));
      ch = 2'($random(seed));
      vt = 3'($random(seed));
      wr(WHB_OFS_BASE_VEC, b);
      wr(WHB_OFS_CHAN_PTR, {6'h0, ~ch});
      @(posedge ref_clk);
      post <= '{1'b1, 2'(k), ch, vt};
      @(posedge ref_clk);
      post <= '0;
      @(posedge ref_clk);
      chk({15'h0, srq_n[k]}, 16'h0);
      rd(WHB_OFS_SRS, 8'(1 << k), 8'h07);
      xfer(1'b1, 2'(k), 1'b1, 7'h00, {b[7:3], vt}, 8'hFF, 1'b0);
      chk({15'h0, srq_n[k]}, 16'h1);
      rd(WHB_OFS_CHAN_PTR, {6'h0, ch}, 8'h03);
      wr(WHB_OFS_EOS, 8'h00);
      xfer(1'b0, 2'h0, 1'b1, WHB_OFS_CHAN_PTR, {6'h0, ~ch}, 8'h03, 1'b1);
    end
    wr(WHB_OFS_CFG, 8'h01);
    wr(WHB_OFS_PWIDTH, 8'h03);
    g = 8'($random(seed));
    wr(WHB_OFS_PDATA, g);
    repeat (20) @(posedge ref_clk);
    chk({8'h00, pdata}, {8'h00, g});
    chk(16'(pwid), 16'd4);
    printer_ack_n_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    printer_ack_n_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(WHB_OFS_PSTAT, 8'h02, 8'h02);
    repeat (4) @(posedge ref_clk);
    chk(16'(exp_q.size()), 16'h0);
    test_done();
  end
endmodule // tb_whb_host_port
